// ### src/ssm_pkg.sv
package ssm_pkg;
   // monitor item select codes
   localparam logic [3:0] ITEM_INPUT_TERM = 4'h0;
   localparam logic [3:0] ITEM_OUTPUT_TERM = 4'h1;
   localparam logic [3:0] ITEM_OP_STATUS = 4'h2;
   localparam logic [3:0] ITEM_CMD_STATUS = 4'h3;
   localparam logic [3:0] ITEM_FUNC_STATUS = 4'h4;
   localparam logic [3:0] ITEM_PID_SP = 4'h5;
   localparam logic [3:0] ITEM_PID_PV = 4'h6;
   localparam logic [3:0] ITEM_PID_MV = 4'h7;
   localparam logic [3:0] ITEM_TUNE = 4'h8;

   // register byte offsets
   localparam logic [4:0] OFS_CTRL = 5'h00;
   localparam logic [4:0] OFS_SEG = 5'h04;
   localparam logic [4:0] OFS_IRQ_STAT = 5'h08;
   localparam logic [4:0] OFS_IRQ_MASK = 5'h0C;
   localparam logic [4:0] OFS_VALUE = 5'h10;

   // control register fields
   localparam int CTRL_ITEM_LSB = 0;
   localparam int CTRL_MSPEED_LSB = 8;
   localparam logic [3:0] ITEM_RESET = 4'h0;
   localparam logic [3:0] MSPEED_RESET = 4'h0;

   // multi-speed settings that enable timer and pulse command segments
   localparam logic [3:0] MSPEED_TIMER_A = 4'h3;
   localparam logic [3:0] MSPEED_TIMER_B = 4'h4;
   localparam logic [3:0] MSPEED_PULSE_A = 4'h5;
   localparam logic [3:0] MSPEED_PULSE_B = 4'h6;

   // segment bit positions: a..h at 0..7, a1..h1 at 8..15
   localparam int SEG_H = 7;
   localparam int SEG_A1 = 8;
   localparam int SEG_B1 = 9;
   localparam int SEG_C1 = 10;
   localparam int SEG_D1 = 11;
   localparam int SEG_E1 = 12;
   localparam int SEG_F1 = 13;

   // interrupt status bits
   localparam int IRQ_TUNE_DONE = 0;
   localparam int IRQ_TUNE_ERR = 1;
   localparam int IRQ_ABNORMAL = 2;
   localparam logic [2:0] IRQ_RESET = 3'h0;

   // tuning progress codes
   localparam logic [2:0] TUNE_IDLE_CODE = 3'h0;
   localparam logic [2:0] TUNE_LAST_STEP = 3'h5;
   localparam logic [2:0] TUNE_DONE_CODE = 3'h6;
   localparam logic [2:0] TUNE_ERR_CODE = 3'h7;

   typedef enum logic [3:0] {
      SSM_TS_IDLE = 4'b0001,
      SSM_TS_RUN = 4'b0010,
      SSM_TS_DONE = 4'b0100,
      SSM_TS_ERR = 4'b1000
   } ssm_tune_state_t;
endpackage

// ### src/ssm_tune_tracker.sv
`timescale 1ns/1ns
module ssm_tune_tracker (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   input wire logic ce,
   // tuning activity
   input wire logic tune_enable,
   input wire logic tune_step,
   input wire logic tune_done,
   input wire logic tune_error,
   // progress
   output logic [2:0] tune_code,
   output logic done_evt,
   output logic err_evt
);
   import ssm_pkg::*;

   typedef struct packed {
      ssm_tune_state_t st;
      logic [2:0] code;
      logic done_evt;
      logic err_evt;
   } ssm_tune_t;

   ssm_tune_t tune_reg;
   ssm_tune_t tune_next;

   always_comb begin
      tune_next = tune_reg;
      tune_next.done_evt = 1'b0;
      tune_next.err_evt = 1'b0;
      case (tune_reg.st)
         SSM_TS_IDLE: begin
            tune_next.code = TUNE_IDLE_CODE; // R13
            if (tune_enable) begin
               tune_next.st = SSM_TS_RUN;
            end
         end
         SSM_TS_RUN: begin
            if (!tune_enable) begin
               tune_next.st = SSM_TS_IDLE;
               tune_next.code = TUNE_IDLE_CODE;
            end else if (tune_error) begin
               // error outranks completion in the same cycle
               tune_next.st = SSM_TS_ERR;
               tune_next.code = TUNE_ERR_CODE; // R14
               tune_next.err_evt = 1'b1;
            end else if (tune_done) begin
               tune_next.st = SSM_TS_DONE;
               tune_next.code = TUNE_DONE_CODE; // R14
               tune_next.done_evt = 1'b1;
            end else if (tune_step && tune_reg.code != TUNE_LAST_STEP) begin
               tune_next.code = tune_reg.code + 3'h1; // R13
            end
         end
         SSM_TS_DONE, SSM_TS_ERR: begin
            // result held until tuning mode is left, then back to 0
            if (!tune_enable) begin
               tune_next.st = SSM_TS_IDLE;
               tune_next.code = TUNE_IDLE_CODE; // R13
            end
         end
         default: begin
            tune_next.st = SSM_TS_IDLE;
            tune_next.code = TUNE_IDLE_CODE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         tune_reg <= '{st: SSM_TS_IDLE, code: TUNE_IDLE_CODE, done_evt: 1'b0,
                       err_evt: 1'b0};
      end else if (ce) begin
         tune_reg <= tune_next;
      end
   end

   assign tune_code = tune_reg.code;
   assign done_evt = tune_reg.done_evt;
   assign err_evt = tune_reg.err_evt;

   a_tune_steps: assert property (@(posedge clk) disable iff (!reset_n)
      ce && tune_reg.st == SSM_TS_RUN && tune_enable && !tune_error
      && !tune_done && tune_step && tune_reg.code < TUNE_LAST_STEP
      |=> tune_code == $past(tune_code) + 3'h1) // R13
      else $error("tuning progress did not advance");
   a_tune_result: assert property (@(posedge clk) disable iff (!reset_n)
      ce && tune_reg.st == SSM_TS_RUN && tune_enable && tune_done
      && !tune_error |=> tune_code == TUNE_DONE_CODE && done_evt) // R14
      else $error("completion code not shown");
endmodule

// ### src/ssm_segment_mapper.sv
// Design decisions made here: the strobed register port and the register offsets.
`timescale 1ns/1ns
// Function
// [R1] input terminal segments a1..g1 follow the seven input terminals.
// [R2] a1 and b1 follow the two open-collector outputs.
// [R3] c1 follows the logical relay state, whatever its excitation mode.
// [R4] operation status segments a..h show eight run and detection flags.
// [R5] a1, b1, c1 show PID tuning, timer run, motor constant tuning.
// [R6] d1, e1, f1 show abnormality, speed search, winding control.
// [R7] command segments show run, reverse, switches, timer and pulse commands.
// [R8] timer command segment needs multi-speed setting 3 or 4 plus command.
// [R9] pulse command segment needs multi-speed setting 5 or 6 plus command.
// [R10] function segments a..h show the first eight terminal functions.
// [R11] function segments a1..h1 show the second eight terminal functions.
// [R12] PID set point, measured and output values are separate percent items.
// [R13] tuning progress starts at 0, steps 1 to 5, returns to 0.
// [R14] tuning progress shows 6 on completion and 7 on error stop.
// [R15] segments are registered each clock with ce high from status, one cycle late; input terminal segments lag their pins three cycles.
module ssm_segment_mapper (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   input wire logic ce,
   // register port
   input wire logic [4:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // control terminal pins
   input wire logic [6:0] input_terminal,
   // drive output states
   input wire logic [1:0] oc_output_closed,
   input wire logic relay_on,
   // operation status
   input wire logic [7:0] op_flags,
   input wire logic pid_tuning,
   input wire logic timer_running,
   input wire logic motor_tuning,
   input wire logic abnormal,
   input wire logic speed_search,
   input wire logic winding_control,
   // command status
   input wire logic run_cmd,
   input wire logic reverse_cmd,
   input wire logic [4:0] switch_cmd,
   input wire logic timer_cmd,
   input wire logic pulse_cmd,
   input wire logic op_cmd_input,
   // terminal functions
   input wire logic [15:0] func_status,
   // pid values in percent
   input wire logic [15:0] pid_set_point,
   input wire logic [15:0] pid_measured,
   input wire logic [15:0] pid_output,
   // tuning progress
   input wire logic tune_enable,
   input wire logic tune_step,
   input wire logic tune_done,
   input wire logic tune_error,
   // display
   output logic [15:0] seg_out,
   output logic [15:0] item_value,
   output logic irq
);
   import ssm_pkg::*;

   typedef struct packed {
      logic [6:0] tin_s1;
      logic [6:0] tin_s2;
      logic [3:0] item;
      logic [3:0] mspeed;
      logic [15:0] seg;
      logic [15:0] value;
      logic [2:0] ists;
      logic [2:0] imask;
      logic abn_prev;
      logic [31:0] rdata;
   } ssm_main_t;

   ssm_main_t m_reg;
   ssm_main_t m_next;
   logic [2:0] tune_code;
   logic done_evt;
   logic err_evt;
   logic [15:0] tin_seg;
   logic [15:0] out_seg;
   logic [15:0] op_seg;
   logic [15:0] cmd_seg;
   logic timer_seg_on;
   logic pulse_seg_on;

   ssm_tune_tracker u_tune (
      .clk(clk),
      .reset_n(reset_n),
      .ce(ce),
      .tune_enable(tune_enable),
      .tune_step(tune_step),
      .tune_done(tune_done),
      .tune_error(tune_error),
      .tune_code(tune_code),
      .done_evt(done_evt),
      .err_evt(err_evt)
   );

   // input terminals drive a1..g1, upper segment h1 and a..h stay dark
   genvar gi;
   generate
      for (gi = 0; gi < 16; gi++) begin : g_tin
         if (gi >= SEG_A1 && gi < SEG_A1 + 7) begin : g_on
            assign tin_seg[gi] = m_reg.tin_s2[gi - SEG_A1]; // R1
         end else begin : g_off
            assign tin_seg[gi] = 1'b0;
         end
      end
   endgenerate

   always_comb begin
      out_seg = 16'h0000;
      out_seg[SEG_A1] = oc_output_closed[0]; // R2
      out_seg[SEG_B1] = oc_output_closed[1]; // R2
      // relay_on is the logical state, excitation mode already resolved
      out_seg[SEG_C1] = relay_on; // R3
   end

   always_comb begin
      op_seg = 16'h0000;
      op_seg[SEG_H:0] = op_flags; // R4
      op_seg[SEG_A1] = pid_tuning; // R5
      op_seg[SEG_B1] = timer_running; // R5
      op_seg[SEG_C1] = motor_tuning; // R5
      op_seg[SEG_D1] = abnormal; // R6
      op_seg[SEG_E1] = speed_search; // R6
      op_seg[SEG_F1] = winding_control; // R6
   end

   always_comb begin
      timer_seg_on = timer_cmd && op_cmd_input
         && (m_reg.mspeed == MSPEED_TIMER_A
         || m_reg.mspeed == MSPEED_TIMER_B); // R8
      pulse_seg_on = pulse_cmd && op_cmd_input
         && (m_reg.mspeed == MSPEED_PULSE_A
         || m_reg.mspeed == MSPEED_PULSE_B); // R9
      cmd_seg = {7'h00, pulse_seg_on, timer_seg_on, switch_cmd,
                 reverse_cmd, run_cmd}; // R7
   end

   always_comb begin
      m_next = m_reg;
      // pins pass two flops before the mapper reads them
      m_next.tin_s1 = input_terminal;
      m_next.tin_s2 = m_reg.tin_s1;
      m_next.abn_prev = abnormal;

      // segments and value refresh every clock with ce high
      case (m_reg.item)
         ITEM_INPUT_TERM: begin
            m_next.seg = tin_seg; // R15
            m_next.value = 16'h0000;
         end
         ITEM_OUTPUT_TERM: begin
            m_next.seg = out_seg; // R15
            m_next.value = 16'h0000;
         end
         ITEM_OP_STATUS: begin
            m_next.seg = op_seg; // R15
            m_next.value = 16'h0000;
         end
         ITEM_CMD_STATUS: begin
            m_next.seg = cmd_seg; // R15
            m_next.value = 16'h0000;
         end
         ITEM_FUNC_STATUS: begin
            m_next.seg = func_status; // R10 R11
            m_next.value = 16'h0000;
         end
         ITEM_PID_SP: begin
            m_next.seg = 16'h0000;
            m_next.value = pid_set_point; // R12
         end
         ITEM_PID_PV: begin
            m_next.seg = 16'h0000;
            m_next.value = pid_measured; // R12
         end
         ITEM_PID_MV: begin
            m_next.seg = 16'h0000;
            m_next.value = pid_output; // R12
         end
         ITEM_TUNE: begin
            m_next.seg = 16'h0000;
            m_next.value = {13'h0000, tune_code}; // R13 R14
         end
         default: begin
            m_next.seg = 16'h0000;
            m_next.value = 16'h0000;
         end
      endcase

      // software writes; write-one-to-clear on status
      if (reg_wr) begin
         case (reg_addr)
            OFS_CTRL: begin
               m_next.item = reg_wdata[CTRL_ITEM_LSB +: 4];
               m_next.mspeed = reg_wdata[CTRL_MSPEED_LSB +: 4];
            end
            OFS_IRQ_STAT: begin
               m_next.ists = m_reg.ists & ~reg_wdata[2:0];
            end
            OFS_IRQ_MASK: begin
               m_next.imask = reg_wdata[2:0];
            end
            default: begin
            end
         endcase
      end
      // set after clear so a same-cycle event is never lost
      if (done_evt) begin
         m_next.ists[IRQ_TUNE_DONE] = 1'b1;
      end
      if (err_evt) begin
         m_next.ists[IRQ_TUNE_ERR] = 1'b1;
      end
      if (abnormal && !m_reg.abn_prev) begin
         m_next.ists[IRQ_ABNORMAL] = 1'b1;
      end

      // read data stands only in the cycle after the strobe
      m_next.rdata = 32'h0000_0000;
      if (reg_rd) begin
         case (reg_addr)
            OFS_CTRL: begin
               m_next.rdata = {20'h00000, m_reg.mspeed, 4'h0, m_reg.item};
            end
            OFS_SEG: begin
               m_next.rdata = {16'h0000, m_reg.seg};
            end
            OFS_IRQ_STAT: begin
               m_next.rdata = {29'h0000_0000, m_reg.ists};
            end
            OFS_IRQ_MASK: begin
               m_next.rdata = {29'h0000_0000, m_reg.imask};
            end
            OFS_VALUE: begin
               m_next.rdata = {16'h0000, m_reg.value};
            end
            default: begin
               m_next.rdata = 32'h0000_0000;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         m_reg <= '{tin_s1: 7'h00, tin_s2: 7'h00, item: ITEM_RESET,
                    mspeed: MSPEED_RESET, seg: 16'h0000,
                    value: 16'h0000, ists: IRQ_RESET, imask: IRQ_RESET,
                    abn_prev: 1'b0, rdata: 32'h0000_0000};
      end else if (ce) begin
         m_reg <= m_next;
      end
   end

   assign seg_out = m_reg.seg;
   assign item_value = m_reg.value;
   assign reg_rdata = m_reg.rdata;
   assign irq = |(m_reg.ists & m_reg.imask);

   // checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   sequence s_pin_settle;
      ce && m_reg.item == ITEM_INPUT_TERM && !reg_wr ##1
      ce && !reg_wr ##1 ce && !reg_wr;
   endsequence

   a_input_follow: assert property ( // R1
      s_pin_settle |=> seg_out[SEG_A1 +: 7] == $past(input_terminal, 3))
      else $error("input terminal segment mismatch");
   a_output_follow: assert property ( // R2
      ce && m_reg.item == ITEM_OUTPUT_TERM
      |=> seg_out[SEG_B1:SEG_A1] == $past(oc_output_closed))
      else $error("open-collector segment mismatch");
   a_relay_follow: assert property ( // R3
      ce && m_reg.item == ITEM_OUTPUT_TERM
      |=> seg_out[SEG_C1] == $past(relay_on) && seg_out[SEG_H:0] == 8'h00)
      else $error("relay segment mismatch");
   a_op_flags: assert property ( // R4
      ce && m_reg.item == ITEM_OP_STATUS
      |=> seg_out[SEG_H:0] == $past(op_flags))
      else $error("operation flag segments mismatch");
   a_op_modes: assert property ( // R5
      ce && m_reg.item == ITEM_OP_STATUS
      |=> seg_out[SEG_C1:SEG_A1]
      == {$past(motor_tuning), $past(timer_running), $past(pid_tuning)})
      else $error("tuning or timer segment mismatch");
   a_op_abnormal: assert property ( // R6
      ce && m_reg.item == ITEM_OP_STATUS
      |=> seg_out[SEG_F1:SEG_D1] == {$past(winding_control),
      $past(speed_search), $past(abnormal)})
      else $error("abnormal or search segment mismatch");
   a_cmd_basic: assert property ( // R7
      ce && m_reg.item == ITEM_CMD_STATUS
      |=> seg_out[6:0] == {$past(switch_cmd), $past(reverse_cmd),
      $past(run_cmd)})
      else $error("command segments mismatch");
   a_timer_gate: assert property ( // R8
      ce && m_reg.item == ITEM_CMD_STATUS && timer_cmd && op_cmd_input
      && (m_reg.mspeed == MSPEED_TIMER_A || m_reg.mspeed == MSPEED_TIMER_B)
      |=> seg_out[SEG_H])
      else $error("timer command segment not lit");
   a_pulse_gate: assert property ( // R9
      ce && m_reg.item == ITEM_CMD_STATUS && seg_out[SEG_A1] == 1'b0
      ##1 ce && seg_out[SEG_A1] |-> $past(op_cmd_input)
      && ($past(m_reg.mspeed) == MSPEED_PULSE_A
      || $past(m_reg.mspeed) == MSPEED_PULSE_B))
      else $error("pulse command segment lit without enable");
   a_func_follow: assert property ( // R10
      ce && m_reg.item == ITEM_FUNC_STATUS
      |=> seg_out == $past(func_status))
      else $error("terminal function segments mismatch");
   a_pid_value: assert property ( // R12
      ce && m_reg.item == ITEM_PID_PV |=> item_value == $past(pid_measured))
      else $error("pid measured value mismatch");
   a_irq_level: assert property ( // R14
      ce && err_evt && m_reg.imask[IRQ_TUNE_ERR]
      && !(reg_wr && reg_addr == OFS_IRQ_MASK) |=> irq)
      else $error("tuning error interrupt missing");
endmodule

// ### verification/ssm_led_panel.sv
`timescale 1ns/1ns
module ssm_led_panel (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // segment drive from the mapper
   input wire logic [15:0] seg_drive,
   // pattern the viewer sees
   output logic [15:0] lit
);
   // the panel registers the drive: dark in reset, else follows drive one clock later
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         lit <= 16'h0000;
      end else begin
         lit <= seg_drive;
      end
   end
endmodule

// ### verification/tb.sv
`timescale 1ns/1ns
module tb;
   import ssm_pkg::*;
   logic clk, reset_n, ce, reg_wr, reg_rd, relay_on, pid_tuning;
   logic timer_running, motor_tuning, abnormal, speed_search;
   logic winding_control, run_cmd, reverse_cmd, timer_cmd, pulse_cmd;
   logic op_cmd_input, tune_enable, tune_step, tune_done, tune_error, irq;
   logic [4:0] reg_addr, switch_cmd;
   logic [31:0] reg_wdata, reg_rdata;
   logic [6:0] input_terminal;
   logic [1:0] oc_output_closed;
   logic [7:0] op_flags;
   logic [15:0] func_status, pid_set_point, pid_measured, pid_output;
   logic [15:0] seg_out, item_value, lit, exp;
   int n_errors = 0;
   int compares = 0;

   ssm_segment_mapper dut_u (.clk(clk), .reset_n(reset_n), .ce(ce),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .input_terminal(input_terminal), .oc_output_closed(oc_output_closed),
      .relay_on(relay_on), .op_flags(op_flags), .pid_tuning(pid_tuning),
      .timer_running(timer_running), .motor_tuning(motor_tuning),
      .abnormal(abnormal), .speed_search(speed_search),
      .winding_control(winding_control), .run_cmd(run_cmd),
      .reverse_cmd(reverse_cmd), .switch_cmd(switch_cmd),
      .timer_cmd(timer_cmd), .pulse_cmd(pulse_cmd),
      .op_cmd_input(op_cmd_input), .func_status(func_status),
      .pid_set_point(pid_set_point), .pid_measured(pid_measured),
      .pid_output(pid_output), .tune_enable(tune_enable),
      .tune_step(tune_step), .tune_done(tune_done),
      .tune_error(tune_error), .seg_out(seg_out),
      .item_value(item_value), .irq(irq));

   ssm_led_panel panel_u (.clk(clk), .reset_n(reset_n),
      .seg_drive(seg_out), .lit(lit));

   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] e,
                      input logic [31:0] g);
      compares++;
      if (g !== e) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic chk_bit(input string what, input logic e, input logic g);
      compares++;
      if (g !== e) begin
         n_errors++;
         $display("BAD %s expected %b seen %b", what, e, g);
      end
   endtask

   // sample a little after the edge so registered outputs have landed
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [4:0] a, input logic [31:0] e);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk("reg_rdata", e, reg_rdata);
   endtask

   task automatic set_item(input logic [3:0] item, input logic [3:0] ms);
      wr(OFS_CTRL, {20'h00000, ms, 4'h0, item});
      settle(1);
   endtask

   task automatic pulse(input logic [2:0] w);
      @(posedge clk);
      {tune_error, tune_done, tune_step} <= w;
      @(posedge clk);
      {tune_error, tune_done, tune_step} <= 3'b000;
   endtask

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // hang guard
   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      complete_run();
   end

   initial begin
      reset_n = 1'b0;
      ce = 1'b1;
      {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
      {input_terminal, oc_output_closed, relay_on, op_flags} = '0;
      {pid_tuning, timer_running, motor_tuning, abnormal} = '0;
      {speed_search, winding_control, run_cmd, reverse_cmd} = '0;
      {switch_cmd, timer_cmd, pulse_cmd, op_cmd_input} = '0;
      {func_status, pid_set_point, pid_measured, pid_output} = '0;
      {tune_enable, tune_step, tune_done, tune_error} = '0;
      repeat (16) @(posedge clk);
      reset_n <= 1'b1;
      rd(OFS_CTRL, 32'h0);
      rd(OFS_IRQ_MASK, 32'h0);
      wr(5'h14, 32'hFFFFFFFF);
      rd(5'h14, 32'h0);
      rd(OFS_CTRL, 32'h0);
      // input terminals pass a synchroniser, so allow its depth
      @(posedge clk);
      input_terminal <= 7'h55;
      settle(4);
      chk("seg_in", 32'h5500, seg_out);
      chk("panel", 32'h5500, lit);
      @(posedge clk);
      input_terminal <= 7'h2A;
      settle(4);
      chk("seg_in", 32'h2A00, seg_out);
      @(posedge clk);
      oc_output_closed <= 2'b10;
      relay_on <= 1'b1;
      set_item(ITEM_OUTPUT_TERM, 4'h0);
      chk("seg_out_term", 32'h0600, seg_out);
      @(posedge clk);
      oc_output_closed <= 2'b01;
      relay_on <= 1'b0;
      settle(2);
      chk("seg_out_term", 32'h0100, seg_out);
      @(posedge clk);
      op_flags <= 8'hA5;
      {pid_tuning, abnormal, winding_control} <= 3'b111;
      set_item(ITEM_OP_STATUS, 4'h0);
      chk("seg_op", 32'h29A5, seg_out);
      @(posedge clk);
      op_flags <= 8'h5A;
      {pid_tuning, abnormal, winding_control} <= 3'b000;
      {timer_running, motor_tuning, speed_search} <= 3'b111;
      #1;
      chk("seg_op", 32'h29A5, seg_out);
      settle(1);
      chk("seg_op", 32'h165A, seg_out);
      rd(OFS_IRQ_STAT, 32'h4);
      chk_bit("irq", 1'b0, irq);
      wr(OFS_IRQ_STAT, 32'h4);
      rd(OFS_IRQ_STAT, 32'h0);
      // multi-speed settings 0 to 7 with an operation command, then 3 and 5 without
      @(posedge clk);
      {run_cmd, switch_cmd, timer_cmd, pulse_cmd} <= 8'hAB;
      op_cmd_input <= 1'b1;
      for (int m = 0; m < 8; m++) begin
         set_item(ITEM_CMD_STATUS, m[3:0]);
         exp = 16'h0029;
         exp[SEG_H] = (m == 3 || m == 4);
         exp[SEG_A1] = (m == 5 || m == 6);
         chk("seg_cmd", {16'h0000, exp}, seg_out);
      end
      rd(OFS_CTRL, 32'h0000_0703);
      @(posedge clk);
      op_cmd_input <= 1'b0;
      {run_cmd, reverse_cmd, switch_cmd} <= 7'h2A;
      set_item(ITEM_CMD_STATUS, 4'h3);
      chk("seg_cmd", 32'h002A, seg_out);
      set_item(ITEM_CMD_STATUS, 4'h5);
      chk("seg_cmd", 32'h002A, seg_out);
      @(posedge clk);
      func_status <= 16'hA55A;
      set_item(ITEM_FUNC_STATUS, 4'h0);
      chk("seg_func", 32'hA55A, seg_out);
      // clock enable low must hold the display as it was
      @(posedge clk);
      ce <= 1'b0;
      func_status <= 16'h0F0F;
      settle(3);
      chk("seg_frozen", 32'hA55A, seg_out);
      @(posedge clk);
      ce <= 1'b1;
      settle(2);
      chk("seg_func", 32'h0F0F, seg_out);
      rd(OFS_SEG, 32'h0000_0F0F);
      @(posedge clk);
      pid_set_point <= 16'h0032;
      pid_measured <= 16'h0019;
      pid_output <= 16'h0064;
      set_item(ITEM_PID_SP, 4'h0);
      chk("pid_sp", 32'h0032, item_value);
      chk("seg_num", 32'h0, seg_out);
      set_item(ITEM_PID_PV, 4'h0);
      chk("pid_pv", 32'h0019, item_value);
      set_item(ITEM_PID_MV, 4'h0);
      chk("pid_mv", 32'h0064, item_value);
      rd(OFS_VALUE, 32'h0000_0064);
      set_item(4'h9, 4'h0);
      chk("seg_none", 32'h0, seg_out);
      // tuning walk: steps saturate at the last step code
      set_item(ITEM_TUNE, 4'h0);
      @(posedge clk);
      tune_enable <= 1'b1;
      settle(3);
      chk("tune", 32'h0, item_value);
      for (int s = 1; s <= 6; s++) begin
         pulse(3'b001);
         settle(1);
         chk("tune", (s > 5) ? 32'h5 : s, item_value);
      end
      pulse(3'b010);
      settle(1);
      chk("tune", 32'h6, item_value);
      chk_bit("irq", 1'b0, irq);
      wr(OFS_IRQ_MASK, 32'h7);
      settle(1);
      chk_bit("irq", 1'b1, irq);
      rd(OFS_IRQ_STAT, 32'h1);
      wr(OFS_IRQ_STAT, 32'h1);
      settle(1);
      chk_bit("irq", 1'b0, irq);
      @(posedge clk);
      tune_enable <= 1'b0;
      settle(3);
      chk("tune", 32'h0, item_value);
      @(posedge clk);
      tune_enable <= 1'b1;
      pulse(3'b001);
      pulse(3'b001);
      settle(1);
      chk("tune", 32'h2, item_value);
      pulse(3'b100);
      settle(1);
      chk("tune", 32'h7, item_value);
      chk_bit("irq", 1'b1, irq);
      rd(OFS_IRQ_STAT, 32'h2);
      wr(OFS_IRQ_MASK, 32'h0);
      settle(1);
      chk_bit("irq", 1'b0, irq);
      wr(OFS_IRQ_STAT, 32'h2);
      rd(OFS_IRQ_STAT, 32'h0);
      complete_run();
   end
endmodule
